/* rtl/ttl0_pkg.sv */
// constants, types and register map of the level 0 time-base block
// assumes a 20 MHz aclk and a CAN core on the same clock
// Function
// - Mode field 11 selects event-driven level 0; gap enable is ignored.
// - In level 0 the trigger memory stays inactive.
// - Time base is kept only by reference messages, no external sync.
// - Time-mark flag sets when cycle time reaches offset value times 0x200.
// - Watch-trigger flag sets at cycle time 0xFF00; no other checks.
// - Register time-mark flag sets when selected time equals time mark.
// - Received frame is reference message when its id matches configured id.
// - Reference messages go from buffer 0 on host request, with ref_offset from phase lock.
// - Sync machine: no gap state, leaves init at zero, synced after two refs.
// - Error level switches only between S0 and S3.
// - Entering S3 clears sync and master state, sets both time flags.
// - S3 ends after next reference sent as master or received as slave.
// - Severe error forces master state machine to master off.
// - Master state changes on observed reference by priority comparison.
// - External sync acts only while node is current time master.
// - With external sync set, trigger rising edge compares cycle time to target.
// - Host setting external sync sets phase lock bit.
// - Phase error above 9 units clears lock and sets schedule master flag.
// - Another node becoming master clears lock and sets schedule master flag.
// - Small phase error keeps lock and becomes next reference offset.
// - Trigger edge detection re-arms each basic cycle; first edge only.
// - Flags stay set until written one; each flag has an enable bit.
package ttl0_pkg;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_REF_ID = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_TARGET = 8'h0c;
  localparam logic [7:0] OFS_TMARK = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_FLAG_EN = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_CYCLE = 8'h20;
  localparam logic [7:0] OFS_OFFSET = 8'h24;
  // field positions
  localparam int CFG_OM_LSB = 0;
  localparam int CFG_GEN_BIT = 2;
  localparam int CFG_IRTO_LSB = 8;
  localparam int CTL_ESC_BIT = 0;
  localparam int CTL_TXREQ_BIT = 1;
  localparam int CTL_PM_BIT = 2;
  localparam int CTL_PRIO_LSB = 4;
  localparam int CTL_TMC_LSB = 8;
  localparam int ST_SYNC_LSB = 0;
  localparam int ST_MS_LSB = 2;
  localparam int ST_EL_LSB = 4;
  localparam int ST_SPL_BIT = 6;
  localparam int FL_TMI = 0;
  localparam int FL_RTMI = 1;
  localparam int FL_WT = 2;
  localparam int FL_GTE = 3;
  localparam int FL_GTD = 4;
  localparam int FL_CSM = 5;
  localparam int NFLAGS = 6;
  // values
  localparam logic [1:0] OM_LEVEL0 = 2'h3;
  localparam logic [1:0] TMC_CYCLE = 2'h1;
  localparam logic [1:0] TMC_LOCAL = 2'h2;
  localparam logic [15:0] WATCH_TIME = 16'hff00;
  localparam int IRTO_SHIFT = 9;
  localparam logic [15:0] PHASE_LIMIT = 16'h0009;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {
    SYNC_OFF = 2'h0,
    SYNC_ING = 2'h1,
    SYNC_IN_SCHED = 2'h3
  } sync_t;
  typedef enum logic [1:0] {
    MS_OFF = 2'h0,
    MS_SLAVE = 2'h1,
    MS_CURRENT = 2'h3,
    MS_BACKUP = 2'h2
  } master_t;
  typedef enum logic [1:0] {
    EL_S0 = 2'h0,
    EL_S3 = 2'h3
  } err_t;
  // frame seen on the bus, one-cycle valid from the CAN core
  typedef struct packed {
    logic valid;
    logic [28:0] id;
    logic disc;
    logic [2:0] prio;
  } ref_rx_t;
endpackage

/* rtl/ttl0_timebase.sv */
// level 0 time base: cycle time, flags, sync/master/error states,
// external phase lock, AXI4-Lite register slave
// assumes frame info and bus-off come from logic on aclk; trigger is a pin
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ttl0_timebase #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // can core side
  input wire logic ntu_tick,
  input wire ttl0_pkg::ref_rx_t rx_frame,
  input wire logic tx_ref_done,
  input wire logic bus_off,
  input wire logic event_trigger,
  output logic tx_ref_req,
  output logic [15:0] ref_offset,
  output logic tmem_active,
  output logic flag_pending
);
  import ttl0_pkg::*;

  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must cover the register map");
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q, rd_word;
  logic [3:0] wstrb_q;
  logic [7:0] awaddr_q;
  logic aw_full_q, w_full_q, wr_go, rd_hit, wr_hit;
  logic [1:0] om_q, tmc_q;
  logic gen_q, esc_q, pm_q, spl_q, tx_req_q, arm_q;
  logic [7:0] irto_q;
  logic [28:0] ref_id_q;
  logic [2:0] prio_q;
  logic [15:0] target_q, tmark_q, ct_q, ct_d, local_q, offset_q;
  logic [NFLAGS-1:0] flags_q, flag_en_q, fl_set, fl_clr;
  sync_t sync_q;
  master_t ms_q;
  err_t el_q;
  logic refcnt_q, tmem_q, pend_q, boff_q;
  logic trig_s1_q, trig_s2_q, trig_s3_q;
  logic level0, rx_ref, ref_evt, ct_chg, tmi_hit, wt_hit, rtm_hit;
  logic s3_hit, s3_exit, master_lost, cmp_go, out_lock, esc_set_wr;
  logic [15:0] diff, abs_diff;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a inside {OFS_CONFIG, OFS_REF_ID, OFS_CONTROL, OFS_TARGET,
      OFS_TMARK, OFS_FLAGS, OFS_FLAG_EN, OFS_STATUS, OFS_CYCLE, OFS_OFFSET};
  endfunction

  // ---- axi4-lite slave ----
  assign wr_go = aw_full_q && w_full_q && !bvalid_q;
  assign wr_hit = wr_go && mapped(awaddr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= RST_WORD;
      wstrb_q <= 4'h0;
    end else begin
      if (!aw_full_q && !awready_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (!w_full_q && !wready_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_full_q <= 1'b1;
        awaddr_q <= awaddr[7:0];
      end
      if (wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_full_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_DECERR;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = RST_WORD;
    rd_hit = mapped(araddr[7:0]);
    unique case (araddr[7:0])
      OFS_CONFIG: begin
        rd_word[CFG_OM_LSB +: 2] = om_q;
        rd_word[CFG_GEN_BIT] = gen_q;
        rd_word[CFG_IRTO_LSB +: 8] = irto_q;
      end
      OFS_REF_ID: rd_word[28:0] = ref_id_q;
      OFS_CONTROL: begin
        rd_word[CTL_ESC_BIT] = esc_q;
        rd_word[CTL_TXREQ_BIT] = tx_req_q;
        rd_word[CTL_PM_BIT] = pm_q;
        rd_word[CTL_PRIO_LSB +: 3] = prio_q;
        rd_word[CTL_TMC_LSB +: 2] = tmc_q;
      end
      OFS_TARGET: rd_word[15:0] = target_q;
      OFS_TMARK: rd_word[15:0] = tmark_q;
      OFS_FLAGS: rd_word[NFLAGS-1:0] = flags_q;
      OFS_FLAG_EN: rd_word[NFLAGS-1:0] = flag_en_q;
      OFS_STATUS: begin
        rd_word[ST_SYNC_LSB +: 2] = sync_q;
        rd_word[ST_MS_LSB +: 2] = ms_q;
        rd_word[ST_EL_LSB +: 2] = el_q;
        rd_word[ST_SPL_BIT] = spl_q;
      end
      OFS_CYCLE: rd_word[15:0] = ct_q;
      OFS_OFFSET: rd_word[15:0] = offset_q;
      default: rd_word = RST_WORD;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= RST_WORD;
      rresp_q <= RESP_OKAY;
    end else begin
      if (!rvalid_q && !arready_q) begin
        arready_q <= 1'b1;
      end
      if (arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---- configuration registers ----
  logic [31:0] wr_ctl;
  assign wr_ctl = merge(RST_WORD, wdata_q, wstrb_q);
  assign esc_set_wr = wr_hit && awaddr_q == OFS_CONTROL && wstrb_q[0]
    && wdata_q[CTL_ESC_BIT] && !esc_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      om_q <= 2'h0;
      gen_q <= 1'b0;
      irto_q <= 8'h00;
      ref_id_q <= 29'h0;
      esc_q <= 1'b0;
      pm_q <= 1'b0;
      prio_q <= 3'h0;
      tmc_q <= 2'h0;
      target_q <= 16'h0000;
      tmark_q <= 16'h0000;
      flag_en_q <= '0;
    end else if (wr_hit) begin
      unique case (awaddr_q)
        OFS_CONFIG: begin
          // gap enable is stored only; level 0 has no gaps
          if (wstrb_q[0]) begin
            om_q <= wdata_q[CFG_OM_LSB +: 2];
            gen_q <= wdata_q[CFG_GEN_BIT];
          end
          if (wstrb_q[1]) begin
            irto_q <= wdata_q[CFG_IRTO_LSB +: 8];
          end
        end
        OFS_REF_ID: ref_id_q <= 29'(merge({3'h0, ref_id_q}, wdata_q,
          wstrb_q));
        OFS_CONTROL: begin
          if (wstrb_q[0]) begin
            esc_q <= wdata_q[CTL_ESC_BIT];
            pm_q <= wdata_q[CTL_PM_BIT];
            prio_q <= wdata_q[CTL_PRIO_LSB +: 3];
          end
          if (wstrb_q[1]) begin
            tmc_q <= wdata_q[CTL_TMC_LSB +: 2];
          end
        end
        OFS_TARGET: target_q <= 16'(merge({16'h0, target_q}, wdata_q,
          wstrb_q));
        OFS_TMARK: tmark_q <= 16'(merge({16'h0, tmark_q}, wdata_q,
          wstrb_q));
        OFS_FLAG_EN: flag_en_q <= NFLAGS'(merge({26'h0, flag_en_q},
          wdata_q, wstrb_q));
        default: ;
      endcase
    end
  end

  // ---- time base ----
  assign level0 = om_q == OM_LEVEL0;
  assign rx_ref = level0 && rx_frame.valid && rx_frame.id == ref_id_q;
  assign ref_evt = rx_ref || (level0 && tx_ref_done);
  assign ct_chg = level0 && (ref_evt || ntu_tick);
  assign ct_d = ref_evt ? 16'h0000 : 16'(ct_q + 16'h0001);
  assign tmi_hit = ct_chg
    && {1'b0, ct_d} == (17'(irto_q) << IRTO_SHIFT);
  assign wt_hit = ct_chg && ct_d == WATCH_TIME;
  assign rtm_hit = level0 && ((tmc_q == TMC_CYCLE && ct_chg
    && ct_d == tmark_q) || (tmc_q == TMC_LOCAL && ntu_tick
    && 16'(local_q + 16'h0001) == tmark_q));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ct_q <= 16'h0000;
      local_q <= 16'h0000;
    end else begin
      if (ct_chg) begin
        ct_q <= ct_d;
      end
      if (level0 && ntu_tick) begin
        local_q <= 16'(local_q + 16'h0001);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmem_q <= 1'b1;
    end else begin
      tmem_q <= !level0;
    end
  end

  // ---- error level ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boff_q <= 1'b0;
    end else begin
      boff_q <= bus_off;
    end
  end

  assign s3_hit = level0 && el_q == EL_S0
    && (wt_hit || (bus_off && !boff_q));
  assign s3_exit = el_q == EL_S3
    && (pm_q ? (level0 && tx_ref_done) : rx_ref);

  always_ff @(posedge aclk) begin
    if (!aresetn || !level0) begin
      el_q <= EL_S0;
    end else if (s3_hit) begin
      el_q <= EL_S3;
    end else if (s3_exit) begin
      el_q <= EL_S0;
    end
  end

  // ---- synchronisation ----
  always_ff @(posedge aclk) begin
    if (!aresetn || !level0 || s3_hit) begin
      sync_q <= SYNC_OFF;
      refcnt_q <= 1'b0;
    end else begin
      unique case (sync_q)
        SYNC_OFF: if (ct_q == 16'h0000) begin
          sync_q <= SYNC_ING;
        end
        SYNC_ING: if (ref_evt) begin
          refcnt_q <= 1'b1;
          if (refcnt_q && !(rx_ref && rx_frame.disc)) begin
            sync_q <= SYNC_IN_SCHED;
          end
        end
        SYNC_IN_SCHED: ;
        default: sync_q <= SYNC_OFF;
      endcase
    end
  end

  // ---- master / slave relation ----
  assign master_lost = rx_ref && ms_q == MS_CURRENT;

  always_ff @(posedge aclk) begin
    if (!aresetn || !level0 || s3_hit || el_q == EL_S3) begin
      ms_q <= MS_OFF;
    end else if (ref_evt) begin
      if (!pm_q) begin
        ms_q <= MS_SLAVE;
      end else if (tx_ref_done) begin
        ms_q <= MS_CURRENT;
      end else if (rx_frame.prio < prio_q) begin
        ms_q <= MS_SLAVE;
      end else begin
        ms_q <= MS_BACKUP;
      end
    end
  end

  // ---- external schedule phase lock ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= event_trigger;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  assign cmp_go = level0 && esc_q && ms_q == MS_CURRENT && arm_q
    && trig_s2_q && !trig_s3_q;
  assign diff = 16'(ct_q - target_q);
  assign abs_diff = diff[15] ? 16'(-diff) : diff;
  assign out_lock = abs_diff > PHASE_LIMIT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_q <= 1'b0;
    end else if (ref_evt) begin
      arm_q <= 1'b1;
    end else if (trig_s2_q && !trig_s3_q) begin
      arm_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spl_q <= 1'b0;
    end else if (esc_set_wr) begin
      spl_q <= 1'b1;
    end else if ((cmp_go && out_lock) || master_lost) begin
      spl_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offset_q <= 16'h0000;
    end else if (cmp_go && !out_lock && spl_q) begin
      offset_q <= diff;
    end else if (level0 && tx_ref_done) begin
      offset_q <= 16'h0000;
    end
  end

  // ---- buffer 0 request ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_req_q <= 1'b0;
    end else if (wr_hit && awaddr_q == OFS_CONTROL && wstrb_q[0]
        && wr_ctl[CTL_TXREQ_BIT]) begin
      tx_req_q <= 1'b1;
    end else if (tx_ref_done) begin
      tx_req_q <= 1'b0;
    end
  end

  // ---- flags: write one clears, a new event wins ----
  always_comb begin
    fl_set = '0;
    fl_set[FL_TMI] = tmi_hit;
    fl_set[FL_RTMI] = rtm_hit;
    fl_set[FL_WT] = wt_hit;
    fl_set[FL_GTE] = s3_hit;
    fl_set[FL_GTD] = s3_hit;
    fl_set[FL_CSM] = (cmp_go && out_lock) || master_lost;
    fl_clr = '0;
    if (wr_hit && awaddr_q == OFS_FLAGS && wstrb_q[0]) begin
      fl_clr = wdata_q[NFLAGS-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
      pend_q <= 1'b0;
    end else begin
      flags_q <= (flags_q & ~fl_clr) | fl_set;
      pend_q <= |(flags_q & flag_en_q);
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign tx_ref_req = tx_req_q;
  assign ref_offset = offset_q;
  assign tmem_active = tmem_q;
  assign flag_pending = pend_q;

  // ---- checks ----
  a_tmi_mark: assert property (level0 && ct_chg
    && {1'b0, ct_d} == (17'(irto_q) << IRTO_SHIFT) |=> flags_q[FL_TMI])
    else $error("time-mark flag missed");
  a_watch_severe: assert property (level0 && el_q == EL_S0 && ct_chg
    && ct_d == WATCH_TIME |=> el_q == EL_S3 && flags_q[FL_WT])
    else $error("watch time did not raise severe level");
  a_level_pair: assert property (el_q == EL_S0 || el_q == EL_S3)
    else $error("illegal error level");
  a_s3_entry: assert property (s3_hit |=> sync_q == SYNC_OFF
    && ms_q == MS_OFF && flags_q[FL_GTE] && flags_q[FL_GTD])
    else $error("severe entry effects missing");
  a_s3_slave_exit: assert property (el_q == EL_S3 && !pm_q && rx_ref
    |=> el_q == EL_S0)
    else $error("severe level not left on reference");
  a_s3_master_off: assert property (el_q == EL_S3
    && $past(el_q) == EL_S3 |-> ms_q == MS_OFF)
    else $error("master state not off in severe level");
  a_esc_lock_set: assert property (esc_set_wr |=> spl_q)
    else $error("phase lock not set on enable");
  a_phase_loss: assert property (cmp_go && out_lock && !esc_set_wr
    |=> !spl_q && flags_q[FL_CSM])
    else $error("phase loss not flagged");
  a_one_edge: assert property (cmp_go && !ref_evt
    |=> !cmp_go [*1] ##0 !arm_q)
    else $error("trigger edge not disarmed");
  a_ref_restart: assert property (ref_evt |=> ct_q == 16'h0000)
    else $error("cycle time not restarted");
  a_tmem_idle: assert property (level0 [*2] |-> !tmem_active)
    else $error("trigger memory active in level 0");
  a_flag_clear: assert property (fl_clr[FL_GTE] && !fl_set[FL_GTE]
    |=> !flags_q[FL_GTE])
    else $error("flag not cleared by write one");
  c_synced: cover property (sync_q == SYNC_ING ##[1:1000]
    sync_q == SYNC_IN_SCHED);
  c_master: cover property (ms_q == MS_CURRENT);
  c_lock_kept: cover property (cmp_go && !out_lock && spl_q);
  c_s3_round: cover property (s3_hit ##[1:1000] s3_exit);
endmodule
`default_nettype wire

/* verification/can_far.sv */
// far-side nodes: time units, reference frames, buffer 0 sending
// assumes the block samples its core-side inputs on rising aclk
`timescale 1ns/1ps
`default_nettype none
module can_far #(
  parameter int DLY = 6
) (
  // clock
  input wire logic aclk,
  // block side
  input wire logic tx_ref_req,
  output logic ntu_tick,
  output var ttl0_pkg::ref_rx_t rx_frame,
  output logic tx_ref_done
);
  import ttl0_pkg::*;
  int n = 0;
  initial begin
    ntu_tick = 1'b1;
    rx_frame = '0;
  end
  // buffer 0 goes out DLY+1 cycles after the request
  always @(posedge aclk) begin
    n <= (tx_ref_req && !tx_ref_done && n < DLY) ? n + 1 : 0;
    tx_ref_done <= tx_ref_req && !tx_ref_done && n == DLY;
  end
  task automatic send(input logic [28:0] id, input logic [2:0] pr);
    @(posedge aclk);
    rx_frame <= '{1'b1, id, 1'b0, pr};
    @(posedge aclk);
    rx_frame <= '{1'b0, ~id, 1'b1, ~pr};
  endtask
endmodule
`default_nettype wire

/* verification/tb_ttl0_timebase.sv */
// bench for the level 0 time base: register bus, trigger pin, bus-off
// assumes can_far supplies time units, frames and buffer 0 sending
`timescale 1ns/1ps
`default_nettype none
module tb_ttl0_timebase;
  import ttl0_pkg::*;
  localparam logic [28:0] REF = 29'h0abc_123;
  localparam logic [31:0] ESC = 32'h1 << CTL_ESC_BIT;
  localparam logic [31:0] TXR = 32'h1 << CTL_TXREQ_BIT;
  localparam logic [31:0] PM = 32'h1 << CTL_PM_BIT;
  localparam logic [31:0] CTL = 32'h3 << CTL_PRIO_LSB | 32'h1 << CTL_TMC_LSB;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, bus_off = 1'b0, event_trigger = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, ntu_tick, tx_ref_done;
  logic tx_ref_req, tmem_active, flag_pending;
  logic [15:0] ref_offset;
  ref_rx_t rx_frame;
  int fail_count = 0;
  int num_checks = 0;

  always #25 aclk = ~aclk;

  ttl0_timebase uut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ntu_tick(ntu_tick), .rx_frame(rx_frame), .tx_ref_done(tx_ref_done),
    .bus_off(bus_off), .event_trigger(event_trigger),
    .tx_ref_req(tx_ref_req), .ref_offset(ref_offset),
    .tmem_active(tmem_active), .flag_pending(flag_pending)
  );
  can_far far (
    .aclk(aclk), .tx_ref_req(tx_ref_req), .ntu_tick(ntu_tick),
    .rx_frame(rx_frame), .tx_ref_done(tx_ref_done)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic hang();
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    final_report();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [2:0] p;
    p = 3'b111;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    for (int i = 0; i < 40 && p != 3'b000; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
      p = p & ~{bvalid, wready, awready};
    end
    if (p != 3'b000) hang();
  endtask
  task automatic rdreg(input logic [7:0] a);
    logic [1:0] p;
    p = 2'b11;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (int i = 0; i < 40 && p != 2'b00; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
      if (rvalid) {rs, rd} = {rresp, rdata};
      p = p & ~{rvalid, arready};
    end
    if (p != 2'b00) hang();
  endtask
  task automatic chkreg(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    rdreg(a);
    chk(rd & m, e);
  endtask
  task automatic txwait();
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (tx_ref_req === 1'b0) return;
    end
    hang();
  endtask
  task automatic pulse();
    event_trigger <= 1'b1;
    cyc(4);
    event_trigger <= 1'b0;
    cyc(4);
  endtask

  task automatic t_setup();
    chk(tmem_active, 1);
    chkreg(OFS_STATUS, 32'h7f, 32'h0);
    rdreg(8'h30);
    chk({rs, rd[29:0]}, {RESP_DECERR, 30'h0});
    wr(OFS_CONFIG, {16'h0, 8'h01, 5'h0, 1'b1, OM_LEVEL0});
    cyc(1);
    chk(tmem_active, 0);
    wr(OFS_REF_ID, {3'h0, REF});
    wr(OFS_FLAG_EN, 32'h3f);
    wr(OFS_TMARK, 32'h100);
    wr(OFS_CONTROL, CTL);
  endtask
  task automatic t_sync_marks();
    far.send(REF, 3'h1);
    chkreg(OFS_STATUS, 32'h7f, {26'h0, EL_S0, MS_SLAVE, SYNC_ING});
    far.send(REF, 3'h1);
    chkreg(OFS_STATUS, 32'h3, {30'h0, SYNC_IN_SCHED});
    cyc(32'h1f0);
    chkreg(OFS_FLAGS, 32'h3, 32'h2);
    cyc(9);
    chkreg(OFS_FLAGS, 32'h3, 32'h3);
    chk(flag_pending, 1);
    wr(OFS_FLAGS, 32'h3f);
    chkreg(OFS_FLAGS, 32'h3f, 32'h0);
    chk(flag_pending, 0);
  endtask
  task automatic t_phase();
    wr(OFS_TARGET, 32'h80);
    wr(OFS_CONTROL, CTL | PM | ESC);
    chkreg(OFS_STATUS, 32'h40, 32'h40);
    wr(OFS_CONTROL, CTL | PM | ESC | TXR);
    chk(tx_ref_req, 1);
    txwait();
    cyc(32'h7c);
    pulse();
    chkreg(OFS_STATUS, 32'h4c, {25'h0, 1'b1, 2'h0, MS_CURRENT, 2'h0});
    chk($signed(ref_offset) < 10 && $signed(ref_offset) > -10, 1);
    pulse();
    chkreg(OFS_STATUS, 32'h40, 32'h40);
    wr(OFS_CONTROL, CTL | PM | ESC | TXR);
    txwait();
    chk(ref_offset, 0);
    cyc(32'h100);
    pulse();
    chkreg(OFS_STATUS, 32'h40, 32'h0);
    chkreg(OFS_FLAGS, 32'h20, 32'h20);
  endtask
  task automatic t_takeover();
    wr(OFS_FLAGS, 32'h3f);
    wr(OFS_CONTROL, CTL | PM);
    wr(OFS_CONTROL, CTL | PM | ESC);
    far.send(REF, 3'h1);
    chkreg(OFS_STATUS, 32'h4c, {26'h0, MS_SLAVE, 2'h0});
    chkreg(OFS_FLAGS, 32'h20, 32'h20);
  endtask
  task automatic t_watch();
    rd = '0;
    for (int i = 0; i < 23000 && rd[FL_WT] !== 1'b1; i++) rdreg(OFS_FLAGS);
    if (rd[FL_WT] !== 1'b1) hang();
    chkreg(OFS_CYCLE, 32'hffc0, 32'hff00);
    chkreg(OFS_STATUS, 32'h7f, {26'h0, EL_S3, MS_OFF, SYNC_OFF});
    chkreg(OFS_FLAGS, 32'h1c, 32'h1c);
    wr(OFS_CONTROL, CTL | PM | TXR);
    txwait();
    chkreg(OFS_STATUS, 32'h30, 32'h0);
  endtask
  task automatic t_busoff();
    wr(OFS_CONTROL, CTL);
    bus_off <= 1'b1;
    cyc(3);
    chkreg(OFS_STATUS, 32'h3c, {26'h0, EL_S3, MS_OFF, 2'h0});
    bus_off <= 1'b0;
    far.send(REF ^ 29'h1, 3'h1);
    chkreg(OFS_STATUS, 32'h30, 32'h30);
    far.send(REF, 3'h1);
    chkreg(OFS_STATUS, 32'h30, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_setup();
    t_sync_marks();
    t_phase();
    t_takeover();
    t_watch();
    t_busoff();
    final_report();
  end
endmodule
`default_nettype wire
